// ---- src/fpk_front_panel.sv ----
/*
  Front-panel key controller: debounced key events, channel selection,
  numeric entry, per-channel settings, fault and protection latches,
  power-on display sequence, Avalon-MM register slave.
  Assumes a keypad scanner giving a held code with a down level, and
  self-test, status and measurement inputs synchronous to mclk_i.
*/
// Summary of operation
// - Select key steps the one active channel forward or backward.
// - Voltage key shows channel voltage setting; digits replace it.
// - Current key shows channel current setting; digits replace it.
// - On/off key toggles channel output; disabled channel shows disabled message.
// - Overvoltage key shows trip level; digits replace it.
// - Overvoltage clear releases crowbar only once its cause is gone.
// - Overcurrent guard key toggles that channel's protection enable.
// - Overcurrent clear restores output only once its cause is gone.
// - Meter key returns display to measured voltage and current.
// - Delay key shows reprogramming delay; digits replace it.
// - Mask key shows mask value; digits replace it.
// - Fault bit sets when status and mask bits are both set.
// - Fault key shows fault register, then clears it.
// - Digit keys build the pending value, shown before commit.
// - Backspace drops last digit; with none entered, goes to metering.
// - Enter commits value, returns to metering; empty entry keeps old value.
// - Boot pass: all segments, bus address about 2 s, then channel one metering.
// - Bus address defaults to five.
// - Self-test failure keeps all outputs off and shows failure and channel.
// - Failure kinds: hardware, bus, timer, converters, fuse; channel one to four.
// - At most one channel lamp lit, marking the selected channel.
// - Error key shows pending error and clears the error flag.
`timescale 1ns/1ps
module fpk_front_panel
  import fpk_pkg::*;
#(
  parameter int LAMP_CYCLES = LAMP_CYC,
  parameter int ADDR_CYCLES = ADDR_CYC,
  parameter int DEB_CYCLES = DEB_CYC
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic key_down_i,
  input wire logic [4:0] key_code_i,
  input wire logic st_done_i,
  input wire logic st_fail_i,
  input wire logic [2:0] st_type_i,
  input wire logic [CH_W-1:0] st_chan_i,
  input wire logic [NCH-1:0][STAT_W-1:0] chan_status_i,
  input wire logic [NCH-1:0] ov_cause_i,
  input wire logic [NCH-1:0] oc_cause_i,
  input wire logic [NCH-1:0] voltage_mode_i,
  input wire logic [NCH-1:0][VAL_W-1:0] meas_v_i,
  input wire logic [NCH-1:0][VAL_W-1:0] meas_i_i,
  input wire logic hw_err_i,
  output logic [NCH-1:0] out_en_o,
  output logic [NCH-1:0] guard_en_o,
  output logic [NCH-1:0] chan_led_o,
  output logic cfg_we_o,
  output fpk_cfg_t cfg_o,
  output fpk_disp_out_t disp_o
);
  localparam int TW = $clog2(LAMP_CYCLES + ADDR_CYCLES + DEB_CYCLES + 1);

  function automatic logic [CH_W-1:0] ch_step(input logic [CH_W-1:0] ch, input logic fwd);
    if (fwd)
      ch_step = (ch == CH_W'(NCH - 1)) ? '0 : ch + 1'b1;
    else
      ch_step = (ch == '0) ? CH_W'(NCH - 1) : ch - 1'b1;
  endfunction

  function automatic logic is_edit(input fpk_disp_t m);
    is_edit = (m == DM_VOLT) || (m == DM_CURR) || (m == DM_OV_LEVEL) ||
              (m == DM_DELAY) || (m == DM_MASK);
  endfunction

  function automatic logic [2:0] fn_of(input fpk_disp_t m);
    case (m)
      DM_CURR: fn_of = FN_CURR;
      DM_OV_LEVEL: fn_of = FN_OV_LEVEL;
      DM_DELAY: fn_of = FN_DELAY;
      DM_MASK: fn_of = FN_MASK;
      default: fn_of = FN_VOLT;
    endcase
  endfunction

  // Key debounce
  logic sync1_reg, sync2_reg, stable_reg, kev_reg;
  logic [4:0] kcode_reg;
  logic [TW-1:0] dcnt_reg;
  // Control state
  fpk_boot_t boot_reg;
  fpk_disp_t mode_reg;
  logic [TW-1:0] tmr_reg;
  logic [CH_W-1:0] sel_reg, fail_chan_reg;
  logic [2:0] fail_type_reg, ecnt_reg;
  logic [VAL_W-1:0] entry_reg;
  logic [NCH-1:0][NFN-1:0][VAL_W-1:0] set_reg;
  logic [NCH-1:0][STAT_W-1:0] fault_reg;
  logic [STAT_W-1:0] fault_view_reg;
  logic [NCH-1:0] out_en_reg, guard_en_reg, ov_latch_reg, oc_latch_reg;
  logic err_pend_reg, err_view_reg, wait_reg, addr_wr_seen_reg;
  logic [4:0] busaddr_reg;
  fpk_disp_out_t dn;

  wire run = (boot_reg == BT_RUN);
  wire kv = kev_reg & run;
  wire k_dig = kv & (kcode_reg <= KEY_DIGIT_MAX);
  wire edit = is_edit(mode_reg);
  wire [2:0] cur_fn = fn_of(mode_reg);
  wire [NCH-1:0] sel_oh = {{(NCH - 1){1'b0}}, 1'b1} << sel_reg;
  wire deb_last = (dcnt_reg == TW'(DEB_CYCLES - 1));
  wire commit = kv & (kcode_reg == KEY_ENTER) & edit & (ecnt_reg != '0);

  // Clear requests; the hardware set terms below win over them
  wire [NCH-1:0] ov_clr = (kv && kcode_reg == KEY_OV_CLEAR) ? sel_oh & ~ov_cause_i : '0;
  wire [NCH-1:0] oc_clr = (kv && kcode_reg == KEY_OC_CLEAR) ? sel_oh & ~oc_cause_i : '0;
  wire [NCH-1:0] fault_clr = (kv && kcode_reg == KEY_FAULT) ? sel_oh : '0;
  wire err_clr = kv & (kcode_reg == KEY_ERR);

  // Bus decode
  wire bus_req = avs_read_i | avs_write_i;
  wire bus_wr = avs_write_i & ~wait_reg;
  wire [7:0] set_rel = avs_address_i - REG_SET_BASE;
  wire set_hit = (avs_address_i >= REG_SET_BASE) && (avs_address_i < REG_SET_END) &&
                 (set_rel[1:0] == 2'b00) && (set_rel[4:2] < 3'(NFN));
  wire [CH_W-1:0] set_ch = set_rel[6:5];
  wire [2:0] set_fn = set_rel[4:2];
  wire [31:0] status_word = {14'h0, err_pend_reg, run, oc_latch_reg, ov_latch_reg,
                             guard_en_reg, out_en_reg};
  wire [31:0] rd_mux = (avs_address_i == REG_STATUS) ? status_word :
                       (avs_address_i == REG_BUSADDR) ? {27'h0, busaddr_reg} :
                       (avs_address_i == REG_SEL) ? {30'h0, sel_reg} :
                       (avs_address_i == REG_FAULT) ? fault_reg :
                       set_hit ? {16'h0, set_reg[set_ch][set_fn]} : 32'h0;

  // One answer cycle per request: waitrequest drops for exactly one cycle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_reg <= 1'b1;
      avs_readdata_o <= '0;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (bus_req && wait_reg)
        avs_readdata_o <= rd_mux;
    end
  end

  always_comb avs_waitrequest_o = wait_reg;

  // Two-flop sync, then a stable-time filter; event only on press
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      stable_reg <= 1'b0;
      dcnt_reg <= '0;
      kev_reg <= 1'b0;
      kcode_reg <= '0;
    end else begin
      sync1_reg <= key_down_i;
      sync2_reg <= sync1_reg;
      kev_reg <= deb_last & sync2_reg & ~stable_reg;
      if (sync2_reg == stable_reg)
        dcnt_reg <= '0;
      else if (deb_last) begin
        dcnt_reg <= '0;
        stable_reg <= sync2_reg;
        kcode_reg <= key_code_i;
      end else
        dcnt_reg <= dcnt_reg + 1'b1;
    end
  end

  // Power-on sequence
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_reg <= BT_WAIT;
      tmr_reg <= '0;
      fail_type_reg <= '0;
      fail_chan_reg <= '0;
    end else begin
      case (boot_reg)
        BT_WAIT: if (st_done_i) begin
          boot_reg <= st_fail_i ? BT_FAIL : BT_LAMP;
          fail_type_reg <= st_type_i;
          fail_chan_reg <= st_chan_i;
        end
        BT_LAMP: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (tmr_reg == TW'(LAMP_CYCLES - 1)) begin
            tmr_reg <= '0;
            boot_reg <= BT_ADDR;
          end
        end
        BT_ADDR: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (tmr_reg == TW'(ADDR_CYCLES - 1)) begin
            tmr_reg <= '0;
            boot_reg <= BT_RUN;
          end
        end
        BT_RUN: boot_reg <= BT_RUN;
        BT_FAIL: boot_reg <= BT_FAIL;
        default: boot_reg <= BT_WAIT;
      endcase
    end
  end

  // Latches where the hardware set wins over a same-cycle clear
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ov_latch_reg <= '0;
      oc_latch_reg <= '0;
      fault_reg <= '0;
      err_pend_reg <= 1'b0;
    end else begin
      ov_latch_reg <= (ov_latch_reg & ~ov_clr) | ov_cause_i;
      oc_latch_reg <= (oc_latch_reg & ~oc_clr) | (oc_cause_i & guard_en_reg);
      err_pend_reg <= (err_pend_reg & ~err_clr) | hw_err_i;
      for (int c = 0; c < NCH; c++)
        fault_reg[c] <= (fault_reg[c] & {STAT_W{~fault_clr[c]}}) |
                        (chan_status_i[c] & set_reg[c][FN_MASK][STAT_W-1:0]);
    end
  end

  // Key interpreter and register writes; a key wins over a bus write
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= DM_METER;
      sel_reg <= '0;
      ecnt_reg <= '0;
      entry_reg <= '0;
      set_reg <= '0;
      out_en_reg <= OUT_EN_RST;
      guard_en_reg <= '0;
      fault_view_reg <= '0;
      err_view_reg <= 1'b0;
      busaddr_reg <= BUSADDR_DEF;
      addr_wr_seen_reg <= 1'b0;
    end else if (k_dig) begin
      if (edit && ecnt_reg < 3'(ENTRY_DIGITS)) begin
        entry_reg <= {entry_reg[VAL_W-5:0], kcode_reg[3:0]};
        ecnt_reg <= ecnt_reg + 1'b1;
      end
    end else if (kv) begin
      ecnt_reg <= '0;
      entry_reg <= '0;
      case (kcode_reg)
        KEY_SEL_FWD, KEY_SEL_REV: begin
          sel_reg <= ch_step(sel_reg, kcode_reg == KEY_SEL_FWD);
          mode_reg <= DM_METER;
        end
        KEY_VOLT: mode_reg <= DM_VOLT;
        KEY_CURR: mode_reg <= DM_CURR;
        KEY_OV_LEVEL: mode_reg <= DM_OV_LEVEL;
        KEY_DELAY: mode_reg <= DM_DELAY;
        KEY_MASK: mode_reg <= DM_MASK;
        KEY_ONOFF: begin
          out_en_reg <= out_en_reg ^ sel_oh;
          mode_reg <= DM_METER;
        end
        KEY_GUARD: guard_en_reg <= guard_en_reg ^ sel_oh;
        KEY_METER, KEY_OV_CLEAR, KEY_OC_CLEAR: mode_reg <= DM_METER;
        KEY_FAULT: begin
          fault_view_reg <= fault_reg[sel_reg];
          mode_reg <= DM_FAULT;
        end
        KEY_ERR: begin
          err_view_reg <= err_pend_reg;
          mode_reg <= DM_ERR;
        end
        KEY_BKSP: begin
          if (ecnt_reg == '0)
            mode_reg <= DM_METER;
          else begin
            entry_reg <= {4'h0, entry_reg[VAL_W-1:4]};
            ecnt_reg <= ecnt_reg - 1'b1;
          end
        end
        KEY_ENTER: begin
          if (commit)
            set_reg[sel_reg][cur_fn] <= entry_reg;
          mode_reg <= DM_METER;
        end
        default: mode_reg <= mode_reg;
      endcase
    end else if (bus_wr) begin
      if (avs_address_i == REG_SEL)
        sel_reg <= avs_writedata_i[CH_W-1:0];
      if (avs_address_i == REG_BUSADDR && avs_writedata_i[4:0] <= BUSADDR_MAX) begin
        busaddr_reg <= avs_writedata_i[4:0];
        addr_wr_seen_reg <= 1'b1;
      end
    end
  end

  // Display contents for the next cycle
  always_comb begin
    dn = '0;
    dn.chan = sel_reg;
    dn.guard_ind = guard_en_reg[sel_reg];
    dn.err_ind = err_pend_reg;
    dn.constant_voltage_indicator = voltage_mode_i[sel_reg];
    case (boot_reg)
      BT_LAMP: begin
        dn.mode = DM_LAMP;
        dn.all_seg = 1'b1;
        dn.constant_voltage_indicator = 1'b1;
        dn.guard_ind = 1'b1;
        dn.err_ind = 1'b1;
      end
      BT_ADDR: begin
        dn.mode = DM_ADDR;
        dn.val_a = {11'h0, busaddr_reg};
      end
      BT_FAIL: begin
        dn.mode = DM_STFAIL;
        dn.chan = fail_chan_reg;
        dn.val_a = {13'h0, fail_type_reg};
      end
      BT_RUN: begin
        dn.mode = mode_reg;
        dn.digits = ecnt_reg;
        if (mode_reg == DM_METER) begin
          if (!out_en_reg[sel_reg])
            dn.mode = DM_DISABLED;
          dn.val_a = meas_v_i[sel_reg];
          dn.val_b = meas_i_i[sel_reg];
        end else if (edit)
          dn.val_a = (ecnt_reg != '0) ? entry_reg : set_reg[sel_reg][cur_fn];
        else if (mode_reg == DM_FAULT)
          dn.val_a = {8'h0, fault_view_reg};
        else
          dn.val_a = {15'h0, err_view_reg};
      end
      default: dn.mode = DM_BLANK;
    endcase
  end

  // Outputs from flops; a failed self-test never enables a channel
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_en_o <= '0;
      guard_en_o <= '0;
      chan_led_o <= '0;
      cfg_we_o <= 1'b0;
      cfg_o <= '0;
      disp_o <= '0;
    end else begin
      out_en_o <= out_en_reg & ~ov_latch_reg & ~oc_latch_reg & {NCH{run}};
      guard_en_o <= guard_en_reg;
      chan_led_o <= run ? sel_oh : '0;
      cfg_we_o <= commit;
      if (commit)
        cfg_o <= '{chan: sel_reg, func: cur_fn, value: entry_reg};
      disp_o <= dn;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_key(logic [4:0] c);
    kv && kcode_reg == c;
  endsequence
  sequence s_lamp_done;
    boot_reg == BT_LAMP && tmr_reg == TW'(LAMP_CYCLES - 1);
  endsequence

  a_led_onehot: assert property ($onehot0(chan_led_o))
    else $error("more than one channel lamp lit");
  a_select_step: assert property (s_key(KEY_SEL_FWD) |=>
    sel_reg == ch_step($past(sel_reg), 1'b1)) else $error("forward select wrong");
  a_onoff_disabled: assert property (run && mode_reg == DM_METER && !out_en_reg[sel_reg]
    |=> disp_o.mode == DM_DISABLED) else $error("disabled message missing");
  a_ov_clear_blocked: assert property (s_key(KEY_OV_CLEAR) ##0 ov_cause_i[sel_reg]
    |=> ov_latch_reg[$past(sel_reg)]) else $error("crowbar cleared with cause present");
  a_guard_toggle: assert property (s_key(KEY_GUARD) |=>
    guard_en_reg != $past(guard_en_reg)) else $error("guard enable not toggled");
  a_fault_set: assert property (1'b1 |=> (fault_reg[0] &
    $past(chan_status_i[0] & set_reg[0][FN_MASK][STAT_W-1:0])) ==
    $past(chan_status_i[0] & set_reg[0][FN_MASK][STAT_W-1:0]))
    else $error("fault bit missed");
  a_fault_view: assert property (s_key(KEY_FAULT) |=>
    fault_view_reg == $past(fault_reg[sel_reg]) && mode_reg == DM_FAULT ##1
    disp_o.val_a[STAT_W-1:0] == fault_view_reg) else $error("fault view wrong");
  a_enter_meter: assert property (s_key(KEY_ENTER) ##0 ecnt_reg == '0
    |=> mode_reg == DM_METER && !cfg_we_o) else $error("empty enter misbehaved");
  a_bksp_meter: assert property (s_key(KEY_BKSP) ##0 ecnt_reg == '0
    |=> mode_reg == DM_METER) else $error("backspace did not meter");
  a_digit_entry: assert property (k_dig && edit && ecnt_reg == '0
    |=> entry_reg[3:0] == $past(kcode_reg[3:0]) && ecnt_reg == 3'h1)
    else $error("digit not taken");
  a_fail_off: assert property (boot_reg == BT_FAIL |=> out_en_o == '0
    && disp_o.mode == DM_STFAIL) else $error("output on after failed self-test");
  a_boot_order: assert property (s_lamp_done |=> boot_reg == BT_ADDR
    ##1 disp_o.mode == DM_ADDR) else $error("address display skipped");
  a_addr_default: assert property (!addr_wr_seen_reg |-> busaddr_reg == BUSADDR_DEF)
    else $error("bus address not default");
  a_key_single: assert property (kev_reg |=> !kev_reg)
    else $error("key event longer than one cycle");
endmodule

// ---- src/fpk_pkg.sv ----
/*
  Shared constants and types for the front-panel key controller: key codes,
  display modes, boot states, self-test failure codes, bus register offsets.
  Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package fpk_pkg;
  localparam int NCH = 4;
  localparam int CH_W = 2;
  localparam int VAL_W = 16;
  localparam int STAT_W = 8;
  localparam int NFN = 5;
  localparam int ENTRY_DIGITS = 4;
  localparam int ADDR_W = 8;

  // Key codes from the keypad scanner; digits occupy their own values
  localparam logic [4:0] KEY_DIGIT_MAX = 5'h09;
  localparam logic [4:0] KEY_SEL_FWD = 5'h10;
  localparam logic [4:0] KEY_SEL_REV = 5'h11;
  localparam logic [4:0] KEY_VOLT = 5'h12;
  localparam logic [4:0] KEY_CURR = 5'h13;
  localparam logic [4:0] KEY_ONOFF = 5'h14;
  localparam logic [4:0] KEY_OV_LEVEL = 5'h15;
  localparam logic [4:0] KEY_OV_CLEAR = 5'h16;
  localparam logic [4:0] KEY_GUARD = 5'h17;
  localparam logic [4:0] KEY_OC_CLEAR = 5'h18;
  localparam logic [4:0] KEY_METER = 5'h19;
  localparam logic [4:0] KEY_DELAY = 5'h1a;
  localparam logic [4:0] KEY_MASK = 5'h1b;
  localparam logic [4:0] KEY_FAULT = 5'h1c;
  localparam logic [4:0] KEY_ERR = 5'h1d;
  localparam logic [4:0] KEY_BKSP = 5'h1e;
  localparam logic [4:0] KEY_ENTER = 5'h1f;

  // Per-channel setting index
  localparam logic [2:0] FN_VOLT = 3'h0;
  localparam logic [2:0] FN_CURR = 3'h1;
  localparam logic [2:0] FN_OV_LEVEL = 3'h2;
  localparam logic [2:0] FN_DELAY = 3'h3;
  localparam logic [2:0] FN_MASK = 3'h4;

  // Self-test failure kinds
  localparam logic [2:0] STF_HDW = 3'h0;
  localparam logic [2:0] STF_BUSIF = 3'h1;
  localparam logic [2:0] STF_TIMER = 3'h2;
  localparam logic [2:0] STF_VOLT_DAC = 3'h3;
  localparam logic [2:0] STF_CC_DAC = 3'h4;
  localparam logic [2:0] STF_OV_DAC = 3'h5;
  localparam logic [2:0] STF_FUSE = 3'h6;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_BUSADDR = 8'h04;
  localparam logic [7:0] REG_SEL = 8'h08;
  localparam logic [7:0] REG_FAULT = 8'h0c;
  localparam logic [7:0] REG_SET_BASE = 8'h40;
  localparam logic [7:0] REG_SET_END = 8'hc0;

  localparam logic [4:0] BUSADDR_DEF = 5'h05;
  localparam logic [4:0] BUSADDR_MAX = 5'h1e;
  localparam logic [NCH-1:0] OUT_EN_RST = 4'hf;

  localparam int CLK_HZ = 20_000_000;
  localparam int LAMP_MS = 2000;
  localparam int ADDR_MS = 2000;
  localparam int DEB_MS = 5;
  localparam int LAMP_CYC = LAMP_MS * (CLK_HZ / 1000);
  localparam int ADDR_CYC = ADDR_MS * (CLK_HZ / 1000);
  localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);

  typedef enum logic [3:0] {
    DM_BLANK, DM_LAMP, DM_ADDR, DM_METER, DM_DISABLED, DM_VOLT, DM_CURR,
    DM_OV_LEVEL, DM_DELAY, DM_MASK, DM_FAULT, DM_ERR, DM_STFAIL
  } fpk_disp_t;

  typedef enum logic [2:0] {BT_WAIT, BT_LAMP, BT_ADDR, BT_RUN, BT_FAIL} fpk_boot_t;

  typedef struct packed {
    fpk_disp_t mode;
    logic [CH_W-1:0] chan;
    logic [VAL_W-1:0] val_a;
    logic [VAL_W-1:0] val_b;
    logic [2:0] digits;
    logic constant_voltage_indicator;
    logic guard_ind;
    logic err_ind;
    logic all_seg;
  } fpk_disp_out_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [2:0] func;
    logic [VAL_W-1:0] value;
  } fpk_cfg_t;
endpackage

// ---- test/fpk_operator.sv ----
/*
  Operator model: presses one key at a time with contact bounce.
  Assumes the caller gives the controller time to debounce (HOLD > DEB).
*/
`timescale 1ns/1ps
module fpk_operator #(
  parameter int HOLD = 12
) (
  input wire logic mclk_i,
  output logic key_down_o,
  output logic [4:0] key_code_o
);
  initial begin
    key_down_o = 1'b0;
    key_code_o = 5'h00;
  end
  // Bounce once on make; code steady while held, scrambled once released
  task automatic press(input logic [4:0] code);
    @(posedge mclk_i);
    key_code_o <= code;
    key_down_o <= 1'b1;
    @(posedge mclk_i);
    key_down_o <= 1'b0;
    @(posedge mclk_i);
    key_down_o <= 1'b1;
    repeat (HOLD) @(posedge mclk_i);
    key_down_o <= 1'b0;
    key_code_o <= ~code;
    repeat (HOLD) @(posedge mclk_i);
  endtask
endmodule

// ---- test/front_panel_key_controller_test.sv ----
/*
  Self-checking bench for the front-panel key controller.
  Assumes short boot and debounce counts and the operator model for keys.
*/
`timescale 1ns/1ps
module front_panel_key_controller_test;
  import fpk_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic st_done = 1'b0;
  logic st_fail = 1'b0;
  logic [NCH-1:0][STAT_W-1:0] status = '0;
  logic [2:0] st_type = STF_FUSE;
  logic [CH_W-1:0] st_chan = 2'h2;
  logic [NCH-1:0] ov_c = 4'h0;
  logic [NCH-1:0] oc_c = 4'h0;
  logic herr = 1'b0;
  logic [NCH-1:0][VAL_W-1:0] mv = '0;
  logic [NCH-1:0] vmode = 4'h1;
  logic kd;
  logic [4:0] kc;
  logic [NCH-1:0] out_en, guard_en, led;
  logic cfg_we;
  fpk_cfg_t cfg, cfg_seen;
  fpk_disp_out_t dsp;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_we = 0;
  logic [31:0] q;
  localparam logic [4:0] FKEY[5] = '{KEY_VOLT, KEY_CURR, KEY_OV_LEVEL, KEY_DELAY, KEY_MASK};
  localparam fpk_disp_t FMODE[5] = '{DM_VOLT, DM_CURR, DM_OV_LEVEL, DM_DELAY, DM_MASK};

  always #25 mclk_i = ~mclk_i;

  fpk_operator #(.HOLD(12)) u_op (.mclk_i(mclk_i), .key_down_o(kd), .key_code_o(kc));

  fpk_front_panel #(.LAMP_CYCLES(8), .ADDR_CYCLES(8), .DEB_CYCLES(4)) u_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .key_down_i(kd), .key_code_i(kc), .st_done_i(st_done),
    .st_fail_i(st_fail), .st_type_i(st_type), .st_chan_i(st_chan), .chan_status_i(status),
    .ov_cause_i(ov_c), .oc_cause_i(oc_c), .voltage_mode_i(vmode), .meas_v_i(mv),
    .meas_i_i('0), .hw_err_i(herr), .out_en_o(out_en), .guard_en_o(guard_en), .chan_led_o(led),
    .cfg_we_o(cfg_we), .cfg_o(cfg), .disp_o(dsp));

  // Committed entries are one-cycle pulses, so latch them as they pass
  always @(posedge mclk_i) begin
    if (cfg_we === 1'b1) begin
      n_we <= n_we + 1;
      cfg_seen <= cfg;
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      $display("BAD %0t bus wait ran out", $time);
      n_mismatch++;
      conclude();
    end
  endtask

  task automatic wait_mode(input fpk_disp_t m);
    int n;
    n = 0;
    while (dsp.mode !== m && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    chk(32'(dsp.mode), 32'(m), "display mode");
    if (n >= 100) begin
      $display("BAD %0t display wait ran out", $time);
      conclude();
    end
  endtask

  task automatic t_boot();
    st_done <= 1'b1;
    wait_mode(DM_LAMP);
    chk(32'(dsp.all_seg), 32'h1, "all segments");
    wait_mode(DM_ADDR);
    wait_mode(DM_METER);
    chk(32'(dsp.constant_voltage_indicator), 32'h1, "constant voltage lamp");
    chk(32'(led), 32'h1, "channel one lamp");
    chk(32'(out_en), 32'hf, "outputs on");
    bus(1'b0, REG_BUSADDR, 32'h0);
    chk(q, 32'h5, "default address");
    bus(1'b1, REG_BUSADDR, 32'd31);
    bus(1'b1, REG_BUSADDR, 32'd14);
    bus(1'b0, REG_BUSADDR, 32'h0);
    chk(q, 32'd14, "address write");
    bus(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0, "unmapped read");
    $display("boot test done");
  endtask

  task automatic t_entry();
    mv[0] <= 16'h1234;
    for (int i = 0; i < 5; i++) begin
      u_op.press(FKEY[i]);
      chk(32'(dsp.mode), 32'(FMODE[i]), "edit mode");
      u_op.press(5'(i + 1));
      u_op.press(5'(i + 5));
      chk(32'(dsp.val_a), 32'((i + 1) * 16 + i + 5), "pending value");
      u_op.press(KEY_ENTER);
      chk(32'(cfg_seen), {11'h0, 2'd0, 3'(i), 16'((i + 1) * 16 + i + 5)}, "commit");
      chk(32'(dsp.mode), 32'(DM_METER), "back to meter");
    end
    chk(32'(n_we), 32'd5, "one commit per enter");
    u_op.press(KEY_CURR);
    u_op.press(5'h7);
    u_op.press(KEY_BKSP);
    chk(32'(dsp.digits), 32'h0, "digit erased");
    u_op.press(KEY_ENTER);
    bus(1'b0, REG_SET_BASE + 8'h04, 32'h0);
    chk(q, 32'h26, "empty enter keeps value");
    u_op.press(KEY_VOLT);
    u_op.press(KEY_BKSP);
    chk(32'(dsp.mode), 32'(DM_METER), "backspace to meter");
    u_op.press(KEY_DELAY);
    u_op.press(KEY_METER);
    chk(32'(dsp.mode), 32'(DM_METER), "meter key");
    chk(32'(dsp.val_a), 32'h1234, "metered voltage");
    $display("entry test done");
  endtask

  task automatic t_fault();
    status[0] <= 8'hff;
    @(posedge mclk_i);
    status[0] <= 8'h00;
    bus(1'b0, REG_FAULT, 32'h0);
    chk(q, 32'h59, "fault is status and mask");
    u_op.press(KEY_FAULT);
    chk(32'(dsp.mode), 32'(DM_FAULT), "fault shown");
    bus(1'b0, REG_FAULT, 32'h0);
    chk(q, 32'h0, "fault cleared");
    herr <= 1'b1;
    @(posedge mclk_i);
    herr <= 1'b0;
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q >> 17, 32'h1, "error pending");
    u_op.press(KEY_ERR);
    chk(32'(dsp.mode), 32'(DM_ERR), "error shown");
    chk(32'(dsp.val_a), 32'h1, "error value");
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q >> 17, 32'h0, "error cleared");
    $display("fault test done");
  endtask

  task automatic t_out();
    u_op.press(KEY_SEL_FWD);
    chk(32'(led), 32'h2, "select forward");
    u_op.press(KEY_SEL_REV);
    u_op.press(KEY_SEL_REV);
    chk(32'(led), 32'h8, "select reverse wraps");
    u_op.press(KEY_SEL_FWD);
    u_op.press(KEY_ONOFF);
    chk(32'(out_en), 32'he, "output off");
    wait_mode(DM_DISABLED);
    u_op.press(KEY_ONOFF);
    u_op.press(KEY_GUARD);
    chk(32'(guard_en), 32'h1, "guard on");
    oc_c <= 4'h1;
    u_op.press(KEY_OC_CLEAR);
    chk(32'(out_en), 32'he, "overcurrent held while cause");
    oc_c <= 4'h0;
    u_op.press(KEY_OC_CLEAR);
    chk(32'(out_en), 32'hf, "overcurrent released");
    u_op.press(KEY_GUARD);
    chk(32'(guard_en), 32'h0, "guard off");
    ov_c <= 4'h1;
    u_op.press(KEY_OV_CLEAR);
    chk(32'(out_en), 32'he, "crowbar held while cause");
    ov_c <= 4'h0;
    u_op.press(KEY_OV_CLEAR);
    chk(32'(out_en), 32'hf, "crowbar released");
    $display("output test done");
  endtask

  task automatic t_stfail();
    arst_n_i <= 1'b0;
    st_done <= 1'b0;
    st_fail <= 1'b1;
    st_type <= STF_TIMER;
    st_chan <= 2'h3;
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    st_done <= 1'b1;
    wait_mode(DM_STFAIL);
    chk(32'(out_en), 32'h0, "outputs held off");
    chk(32'(dsp.chan), 32'h3, "failed channel");
    chk(32'(dsp.val_a), 32'(STF_TIMER), "failure kind");
    $display("self-test failure test done");
  endtask

  initial begin
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    t_boot();
    t_entry();
    t_fault();
    t_out();
    t_stfail();
    conclude();
  end
endmodule
